// File: hw/pcipm_regs.sv
// Summary of operation
// RULE1: Capability bit 9 reads one, light sleep state supported.
// RULE2: Capability bits 8 to 6 always read zero.
// RULE3: Capability bit 5 reads zero, no special initialisation.
// RULE4: Aux supply bit reads one only while cold wake bit is set.
// RULE5: Bus clock bit reads zero, wake needs no bus clock.
// RULE6: Capability bits 2 to 0 read 010.
// RULE7: Wake context cleared by global reset; bus reset too when wake disabled.
// RULE8: Control/status word survives the internal reset on leaving D3hot.
// RULE9: Leaving D3hot pulses function reset; context bits kept while wake enabled.
// RULE10: Wake status sets on every wake event, whatever the enable. Code drops an event that meets ctx_clear in the same cycle.
// RULE11: Writing one clears wake status and releases the wake pin.
// RULE12: Report scale and report select fields always read zero.
// RULE13: Wake pin never driven while wake enable bit is clear.
// RULE14: Wake enable ignores bus reset, cleared only by global reset.
// RULE15: Control/status bits 7 to 2 always read zero.
// RULE16: Power state field reads current state, write moves the function.
// RULE17: Power state encoding 00 D0, 01 D1, 10 D2, 11 D3hot.
// RULE18: Cold wake capability bit is writable, defaults to one.
// RULE19: Writes to fixed fields are ignored.
`timescale 1ns/100ps
module pcipm_regs (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic [pcipm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [pcipm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [pcipm_pkg::DATA_W-1:0]  rdata,
  input  wire logic                          global_reset_in_n,
  input  wire logic                          bus_reset_in_n,
  input  wire logic                          wake_event_in,
  input  wire logic                          wake_pin_i,
  output logic                               wake_pin_o,
  output logic                               wake_pin_oe,
  output pcipm_pkg::pcipm_pstate_t           power_state,
  output logic                               func_reset,
  output logic                               irq
);
  import pcipm_pkg::*;

  pcipm_sync_if sif ();

  logic                  cold_wake_ff;
  logic                  wake_status_ff;
  logic                  wake_enable_bit_ff;
  pcipm_pstate_t         power_state_ff;
  logic                  wake_drive_ff;
  logic                  func_reset_ff;
  logic                  line_prev_ff;
  logic [IRQ_W-1:0]      irq_stat_ff;
  logic [IRQ_W-1:0]      irq_mask_ff;
  logic [DATA_W-1:0]     rdata_ff;

  logic                  nxt_cold_wake;
  logic                  nxt_wake_status;
  logic                  nxt_wake_enable;
  pcipm_pstate_t         nxt_power_state;
  logic [IRQ_W-1:0]      nxt_irq_stat;
  logic [IRQ_W-1:0]      nxt_irq_mask;
  logic [DATA_W-1:0]     nxt_rdata;

  logic [DATA_W-1:0]     cap_value;
  logic [DATA_W-1:0]     csr_value;

  wire                   sel_cap   = (addr == OFS_CAP);
  wire                   sel_csr   = (addr == OFS_CSR);
  wire                   sel_istat = (addr == OFS_IRQ_STAT);
  wire                   sel_imask = (addr == OFS_IRQ_MASK);
  wire                   wr_cap    = wr_stb & sel_cap;
  wire                   wr_csr    = wr_stb & sel_csr;
  wire                   wr_istat  = wr_stb & sel_istat;
  wire                   wr_imask  = wr_stb & sel_imask;

  wire                   global_reset_in_act  = ~sif.clean[SYN_GLOBAL_RESET_IN];
  wire                   brst_act  = ~sif.clean[SYN_BRST];
  wire                   line_low  = ~sif.clean[SYN_LINE];
  wire                   any_rst   = global_reset_in_act | brst_act;
  // Context bits: bus reset only counts while wake is disabled
  wire                   ctx_clear = global_reset_in_act | (brst_act & ~wake_enable_bit_ff); // [RULE7]

  pcipm_pstate_t         ps_wr_val;
  assign ps_wr_val = pcipm_pstate_t'(wdata[1:0]);                 // [RULE17]
  wire                   ps_write  = wr_csr & ~any_rst;
  // Internal reset only on the D3hot to D0 step
  wire                   d3_exit   = ps_write & (power_state_ff == PS_D3HOT) & (ps_wr_val == PS_D0);
  wire                   ps_change = ps_write & (ps_wr_val != power_state_ff);
  wire                   line_fall = line_low & ~line_prev_ff;
  wire                   wake_clr  = wr_csr & wdata[CSR_WSTAT];

  wire [IRQ_W-1:0]       irq_event;
  assign irq_event[IRQ_WAKE]  = wake_event_in;
  assign irq_event[IRQ_PSCHG] = ps_change;
  assign irq_event[IRQ_FRST]  = d3_exit;
  assign irq_event[IRQ_LINE]  = line_fall;

  assign sif.raw[SYN_GLOBAL_RESET_IN] = global_reset_in_n;
  assign sif.raw[SYN_BRST] = bus_reset_in_n;
  assign sif.raw[SYN_LINE] = wake_pin_i;

  pcipm_sync u_sync (
    .mclk (mclk),
    .srst (srst),
    .sif  (sif.filter)
  );

  // Capabilities word; fixed fields come from constants, so writes cannot touch them
  always_comb begin
    cap_value              = CAP_FIXED;                          // [RULE1] [RULE2] [RULE3] [RULE19]
    cap_value[2:0]         = CAP_VERSION;                        // [RULE6]
    cap_value[CAP_COLD_WAKE] = cold_wake_ff;                     // [RULE18]
    cap_value[CAP_AUX]     = aux_supply_needed & cold_wake_ff;   // [RULE4]
    cap_value[CAP_BUSCLK]  = wake_needs_bus_clock;               // [RULE5]
  end

  always_comb begin
    csr_value            = '0;                                   // [RULE12] [RULE15] [RULE19]
    csr_value[CSR_WSTAT] = wake_status_ff;
    csr_value[CSR_WEN]   = wake_enable_bit_ff;
    csr_value[1:0]       = power_state_ff;                       // [RULE16]
  end

  assign nxt_rdata = !rd_stb   ? '0 :
                     sel_cap   ? cap_value :
                     sel_csr   ? csr_value :
                     sel_istat ? DATA_W'(irq_stat_ff) :
                     sel_imask ? DATA_W'(irq_mask_ff) :
                     '0;

  // Cold wake bit is a context bit: kept across D3hot exit while enabled
  assign nxt_cold_wake = (ctx_clear | (d3_exit & ~wake_enable_bit_ff)) ? COLD_WAKE_RESET : // [RULE7] [RULE9]
                         wr_cap ? wdata[CAP_COLD_WAKE] :                                   // [RULE18]
                         cold_wake_ff;

  // Event wins over a write-one clear in the same cycle; ctx_clear wins over both
  assign nxt_wake_status = ctx_clear     ? 1'b0 :                // [RULE7]
                           wake_event_in ? 1'b1 :                // [RULE10]
                           wake_clr      ? 1'b0 :                // [RULE11]
                           wake_status_ff;

  assign nxt_wake_enable = global_reset_in_act ? 1'b0 :                     // [RULE14]
                           wr_csr   ? wdata[CSR_WEN] :
                           wake_enable_bit_ff;

  // Internal reset leaves this field alone; only the written value lands
  assign nxt_power_state = any_rst  ? PS_D0 :
                           ps_write ? ps_wr_val :                // [RULE16] [RULE8]
                           power_state_ff;

  for (genvar g = 0; g < IRQ_W; g++) begin : g_irq
    assign nxt_irq_stat[g] = irq_event[g] | (irq_stat_ff[g] & ~(wr_istat & wdata[g]));
  end

  assign nxt_irq_mask = wr_imask ? wdata[IRQ_W-1:0] : irq_mask_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cold_wake_ff       <= COLD_WAKE_RESET;
      wake_status_ff     <= 1'b0;
      wake_enable_bit_ff <= 1'b0;
      power_state_ff     <= PS_D0;
      wake_drive_ff      <= 1'b0;
    end else begin
      cold_wake_ff       <= nxt_cold_wake;
      wake_status_ff     <= nxt_wake_status;
      wake_enable_bit_ff <= nxt_wake_enable;
      power_state_ff     <= nxt_power_state;
      wake_drive_ff      <= nxt_wake_status & nxt_wake_enable;  // [RULE13] [RULE11]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      func_reset_ff <= 1'b0;
      line_prev_ff  <= 1'b0;
      rdata_ff      <= '0;
    end else begin
      func_reset_ff <= d3_exit;                                  // [RULE9]
      line_prev_ff  <= line_low;
      rdata_ff      <= nxt_rdata;
    end
  end

  // Software interrupt registers sit outside the function reset domain
  always_ff @(posedge mclk) begin
    if (srst || global_reset_in_act) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign rdata       = rdata_ff;
  assign wake_pin_o  = 1'b0;
  assign wake_pin_oe = wake_drive_ff;
  assign power_state = power_state_ff;
  assign func_reset  = func_reset_ff;
  assign irq         = |(irq_stat_ff & irq_mask_ff);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  cap_d1_read_a: assert property (rd_stb && sel_cap |=> rdata[9]) // [RULE1]
    else $error("light sleep support bit not one");

  cap_rsvd_read_a: assert property (rd_stb && sel_cap |=> (rdata & CAP_RSVD) == '0) // [RULE2]
    else $error("reserved capability bits not zero");

  cap_init_bit_a: assert property (rd_stb && sel_cap |=> !rdata[5]) // [RULE3]
    else $error("initialisation bit not zero");

  cap_aux_read_a: assert property (rd_stb && sel_cap |=> rdata[CAP_AUX] == rdata[CAP_COLD_WAKE]) // [RULE4]
    else $error("aux supply bit disagrees with cold wake bit");

  cap_busclk_a: assert property (rd_stb && sel_cap |=> !rdata[CAP_BUSCLK]) // [RULE5]
    else $error("bus clock bit not zero");

  cap_version_a: assert property (rd_stb && sel_cap |=> rdata[2:0] == 3'h2) // [RULE6]
    else $error("version field wrong");

  ctx_keep_a: assert property ( // [RULE7]
    brst_act && !global_reset_in_act && wake_enable_bit_ff && wake_status_ff && !wake_clr |=> wake_status_ff)
    else $error("wake status lost on bus reset while enabled");

  ctx_clear_a: assert property ( // [RULE7]
    brst_act && !wake_enable_bit_ff |=> !wake_status_ff && cold_wake_ff)
    else $error("context bits kept on bus reset while disabled");

  d3_exit_keep_a: assert property ( // [RULE8]
    d3_exit |=> power_state_ff == PS_D0 && wake_enable_bit_ff == $past(wdata[CSR_WEN]))
    else $error("control word disturbed by internal reset");

  func_pulse_a: assert property (d3_exit |=> func_reset ##1 !func_reset) // [RULE9]
    else $error("function reset pulse wrong");

  func_cause_a: assert property ($rose(func_reset) |-> $past(power_state_ff) == PS_D3HOT) // [RULE9]
    else $error("function reset without D3hot exit");

  wake_set_a: assert property (wake_event_in && !ctx_clear |=> wake_status_ff) // [RULE10]
    else $error("wake event not recorded");

  wake_clear_a: assert property ( // [RULE11]
    wake_clr && !wake_event_in && !ctx_clear |=> !wake_status_ff && !wake_pin_oe)
    else $error("wake status not cleared by write of one");

  wake_zero_wr_a: assert property ( // [RULE11]
    wr_csr && !wdata[CSR_WSTAT] && wake_status_ff && !ctx_clear |=> wake_status_ff)
    else $error("write of zero cleared wake status");

  csr_zero_a: assert property ( // [RULE12] [RULE15]
    rd_stb && sel_csr |=> (rdata & (CSR_ZERO_HI | CSR_ZERO_LO)) == '0)
    else $error("fixed control fields not zero");

  wake_gate_a: assert property (wake_pin_oe |-> wake_enable_bit_ff && wake_status_ff) // [RULE13]
    else $error("wake pin driven while disabled");

  wen_bus_rst_a: assert property ( // [RULE14]
    brst_act && !global_reset_in_act && !wr_csr |=> $stable(wake_enable_bit_ff))
    else $error("wake enable changed by bus reset");

  ps_write_a: assert property ( // [RULE16] [RULE17]
    wr_csr && !any_rst |=> power_state == pcipm_pstate_t'($past(wdata[1:0])))
    else $error("power state not taken from write");

  ps_read_a: assert property (rd_stb && sel_csr |=> rdata[1:0] == $past(power_state_ff)) // [RULE16]
    else $error("power state read back wrong");

  cold_wr_a: assert property (wr_cap && !ctx_clear && !d3_exit |=> cold_wake_ff == $past(wdata[CAP_COLD_WAKE])) // [RULE18]
    else $error("cold wake bit not writable");

  global_reset_in_ctx_a: assert property ( // [RULE7] [RULE14]
    global_reset_in_act |=> !wake_status_ff && !wake_enable_bit_ff && cold_wake_ff)
    else $error("global reset left context bits set");

  wen_write_a: assert property ( // [RULE13]
    wr_csr && !global_reset_in_act |=> wake_enable_bit_ff == $past(wdata[CSR_WEN]))
    else $error("wake enable bit not writable");

  wake_drive_a: assert property ( // [RULE13]
    wake_status_ff && wake_enable_bit_ff |-> wake_pin_oe)
    else $error("wake pin not driven while enabled and pending");

  d3_status_keep_a: assert property ( // [RULE8]
    d3_exit && !wake_event_in && !wake_clr |=> $stable(wake_status_ff))
    else $error("wake status disturbed by internal reset");

  cold_exit_rst_a: assert property ( // [RULE9]
    d3_exit && !wake_enable_bit_ff |=> cold_wake_ff)
    else $error("cold wake bit kept on exit while wake disabled");

  func_idle_a: assert property ( // [RULE9]
    !d3_exit |=> !func_reset)
    else $error("function reset without exit request");

  brst_state_a: assert property ( // [RULE16]
    brst_act |=> power_state == PS_D0)
    else $error("bus reset did not force D0");

  ps_rst_hold_a: assert property ( // [RULE16]
    wr_csr && any_rst |=> power_state == PS_D0)
    else $error("power state written during pin reset");

  rdata_idle_a: assert property (
    !rd_stb |=> rdata == '0)
    else $error("read data not zero outside read cycle");

  rdata_unmapped_a: assert property (
    rd_stb && !(sel_cap || sel_csr || sel_istat || sel_imask) |=> rdata == '0)
    else $error("unmapped read not zero");

  // Interrupt registers: sticky, set wins over a clear
  irq_wake_set_a: assert property (
    wake_event_in && !global_reset_in_act |=> irq_stat_ff[IRQ_WAKE])
    else $error("wake interrupt bit not set");

  irq_pschg_set_a: assert property (
    ps_change |=> irq_stat_ff[IRQ_PSCHG])
    else $error("state change interrupt bit not set");

  irq_exit_set_a: assert property (
    d3_exit |=> irq_stat_ff[IRQ_FRST])
    else $error("exit interrupt bit not set");

  irq_line_set_a: assert property (
    line_fall && !global_reset_in_act |=> irq_stat_ff[IRQ_LINE])
    else $error("line fall interrupt bit not set");

  irq_w1c_a: assert property (
    wr_istat && !global_reset_in_act && (irq_event & wdata[IRQ_W-1:0]) == '0 |=> (irq_stat_ff & $past(wdata[IRQ_W-1:0])) == '0)
    else $error("interrupt status not cleared by write of one");

  irq_mask_wr_a: assert property (
    wr_imask && !global_reset_in_act |=> irq_mask_ff == $past(wdata[IRQ_W-1:0]))
    else $error("interrupt mask not writable");

  irq_global_reset_in_a: assert property (
    global_reset_in_act |=> irq_stat_ff == '0 && irq_mask_ff == '0)
    else $error("interrupt registers kept over global reset");

  irq_level_a: assert property (
    (irq_stat_ff & irq_mask_ff) != '0 |-> irq)
    else $error("interrupt output low with unmasked status");

endmodule

// File: hw/pcipm_sync.sv
`timescale 1ns/100ps
module pcipm_sync (
  input wire logic  mclk,
  input wire logic  srst,
  pcipm_sync_if.filter sif
);
  import pcipm_pkg::*;

  logic [SYN_W-1:0] s1_ff;
  logic [SYN_W-1:0] s2_ff;
  logic [SYN_W-1:0] s3_ff;
  logic [SYN_W-1:0] clean_ff;

  // A lane changes only once stages two and three agree
  for (genvar g = 0; g < SYN_W; g++) begin : g_lane
    always_ff @(posedge mclk) begin
      if (srst) begin
        s1_ff[g]    <= SYN_IDLE[g];
        s2_ff[g]    <= SYN_IDLE[g];
        s3_ff[g]    <= SYN_IDLE[g];
        clean_ff[g] <= SYN_IDLE[g];
      end else begin
        s1_ff[g] <= sif.raw[g];
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        if (s2_ff[g] == s3_ff[g]) begin
          clean_ff[g] <= s3_ff[g];
        end
      end
    end
  end

  assign sif.clean = clean_ff;

endmodule

// File: shared/pcipm_pkg.sv
package pcipm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets on the configuration port
  localparam logic [ADDR_W-1:0] OFS_CAP       = 8'ha2;
  localparam logic [ADDR_W-1:0] OFS_CSR       = 8'ha4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'hc0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'hc2;

  // Capabilities word layout
  localparam int CAP_COLD_WAKE = 15;
  localparam int CAP_AUX       = 4;
  localparam int CAP_BUSCLK    = 3;
  localparam logic [DATA_W-1:0] CAP_FIXED = 16'h7e02;
  localparam logic [DATA_W-1:0] CAP_RSVD  = 16'h01e0;
  localparam logic [2:0]        CAP_VERSION = 3'h2;
  localparam logic aux_supply_needed    = 1'h1;
  localparam logic wake_needs_bus_clock = 1'h0;
  localparam logic COLD_WAKE_RESET      = 1'h1;

  // Control/status word layout
  localparam int CSR_WSTAT = 15;
  localparam int CSR_WEN   = 8;
  localparam logic [DATA_W-1:0] CSR_ZERO_HI = 16'h7e00;
  localparam logic [DATA_W-1:0] CSR_ZERO_LO = 16'h00fc;

  typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3HOT} pcipm_pstate_t;

  // Interrupt status/mask layout
  localparam int IRQ_WAKE  = 0;
  localparam int IRQ_PSCHG = 1;
  localparam int IRQ_FRST  = 2;
  localparam int IRQ_LINE  = 3;
  localparam int IRQ_W     = 4;

  // Pin synchroniser lanes, all idle high
  localparam int SYN_GLOBAL_RESET_IN = 0;
  localparam int SYN_BRST = 1;
  localparam int SYN_LINE = 2;
  localparam int SYN_W    = 3;
  localparam logic [SYN_W-1:0] SYN_IDLE = 3'h7;

endpackage

// File: shared/pcipm_sync_if.sv
`timescale 1ns/100ps
interface pcipm_sync_if;
  import pcipm_pkg::*;
  logic [SYN_W-1:0] raw;
  logic [SYN_W-1:0] clean;
  modport owner  (output raw, input clean);
  modport filter (input raw, output clean);
endinterface

// File: verif/pcipm_regs_tb.sv
`timescale 1ns/100ps
module testbench;
  import pcipm_pkg::*;
  logic                mclk;
  logic                srst;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                wr_stb;
  logic                rd_stb;
  logic [DATA_W-1:0]   rdata;
  logic                global_reset_in_n;
  logic                bus_reset_in_n;
  logic                wake_event_in;
  logic                wake_line;
  logic                wake_pin_o;
  logic                wake_pin_oe;
  pcipm_pstate_t       power_state;
  logic                func_reset;
  logic                irq;
  int                  errors;
  int                  comparisons;

  // Open-drain wake line, pulled up when nobody drives it
  assign wake_line = wake_pin_oe ? wake_pin_o : 1'h1;

  pcipm_regs u_pcipm_regs (
    .mclk              (mclk),
    .srst              (srst),
    .addr              (addr),
    .wdata             (wdata),
    .wr_stb            (wr_stb),
    .rd_stb            (rd_stb),
    .rdata             (rdata),
    .global_reset_in_n (global_reset_in_n),
    .bus_reset_in_n    (bus_reset_in_n),
    .wake_event_in     (wake_event_in),
    .wake_pin_i        (wake_line),
    .wake_pin_o        (wake_pin_o),
    .wake_pin_oe       (wake_pin_oe),
    .power_state       (power_state),
    .func_reset        (func_reset),
    .irq               (irq)
  );

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("Errors: %0d, comparisons: %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Returns just after the edge that takes the write, so effects are visible
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    @(posedge mclk);
    wr_stb <= 1'h0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge mclk);
    rd_stb <= 1'h0;
    #1;
    check(rdata, exp, what);
  endtask

  task automatic wake_pulse;
    @(posedge mclk);
    wake_event_in <= 1'h1;
    @(posedge mclk);
    wake_event_in <= 1'h0;
    #1;
  endtask

  // Pins pass a synchroniser, so hold and settle well past its depth
  task automatic pin_reset(input logic is_global);
    @(posedge mclk);
    if (is_global) begin
      global_reset_in_n <= 1'h0;
    end else begin
      bus_reset_in_n <= 1'h0;
    end
    repeat (8) @(posedge mclk);
    global_reset_in_n <= 1'h1;
    bus_reset_in_n    <= 1'h1;
    repeat (8) @(posedge mclk);
  endtask

  initial begin
    #(40 * 20000);
    errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    srst = 1'h1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    global_reset_in_n = 1'h1;
    bus_reset_in_n = 1'h1;
    wake_event_in = 1'h0;
    errors = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    rd(OFS_CAP, 16'hfe12, "cap default");
    @(posedge mclk);
    #1;
    check(rdata, 16'h0000, "rdata after read cycle");
    rd(OFS_CSR, 16'h0000, "csr default");
    wr(OFS_CAP, 16'h81ff);
    rd(OFS_CAP, 16'hfe12, "cap fixed bits");
    wr(OFS_CAP, 16'h7fff);
    rd(OFS_CAP, 16'h7e02, "cap without cold wake");
    wr(OFS_CAP, 16'h8000);
    // Zero fields written as ones while stepping through every state
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CSR, 16'h7efc | {14'h0, i[1:0]});
      check({14'h0, power_state}, {14'h0, i[1:0]}, "power state pin");
      rd(OFS_CSR, {14'h0, i[1:0]}, "csr state");
    end
    wr(OFS_CSR, 16'h0103);
    wr(OFS_CAP, 16'h0000);
    wr(OFS_CSR, 16'h0100);
    check({15'h0, func_reset}, 16'h0001, "function reset pulse");
    check({14'h0, power_state}, 16'h0000, "state after exit");
    rd(OFS_CSR, 16'h0100, "csr across exit");
    check({15'h0, func_reset}, 16'h0000, "function reset ended");
    rd(OFS_CAP, 16'h7e02, "context kept with wake on");
    wr(OFS_CSR, 16'h0003);
    wr(OFS_CSR, 16'h0000);
    rd(OFS_CAP, 16'hfe12, "context reset with wake off");
    wr(OFS_CSR, 16'h0100);
    wake_pulse();
    check({15'h0, wake_pin_oe}, 16'h0001, "wake driven");
    rd(OFS_CSR, 16'h8100, "wake status set");
    wr(OFS_CSR, 16'h0100);
    rd(OFS_CSR, 16'h8100, "zero write keeps status");
    wr(OFS_CSR, 16'h8100);
    check({15'h0, wake_pin_oe}, 16'h0000, "wake released");
    rd(OFS_CSR, 16'h0100, "status cleared");
    wr(OFS_CSR, 16'h0000);
    wake_pulse();
    check({15'h0, wake_pin_oe}, 16'h0000, "wake gated off");
    rd(OFS_CSR, 16'h8000, "status without enable");
    wr(OFS_CAP, 16'h0000);
    wr(OFS_CSR, 16'h0002);
    pin_reset(1'h0);
    rd(OFS_CSR, 16'h0000, "bus reset, wake off");
    rd(OFS_CAP, 16'hfe12, "bus reset cap, wake off");
    wr(OFS_CSR, 16'h0102);
    wr(OFS_CAP, 16'h0000);
    wake_pulse();
    pin_reset(1'h0);
    rd(OFS_CSR, 16'h8100, "bus reset, wake on");
    rd(OFS_CAP, 16'h7e02, "bus reset cap, wake on");
    pin_reset(1'h1);
    rd(OFS_CSR, 16'h0000, "global reset csr");
    rd(OFS_CAP, 16'hfe12, "global reset cap");
    wr(OFS_IRQ_STAT, 16'h000f);
    rd(OFS_IRQ_STAT, 16'h0000, "irq status clear");
    wake_pulse();
    rd(OFS_IRQ_STAT, 16'h0001, "irq wake event");
    check({15'h0, irq}, 16'h0000, "irq masked");
    wr(OFS_IRQ_MASK, 16'h0001);
    check({15'h0, irq}, 16'h0001, "irq raised");
    wr(OFS_IRQ_STAT, 16'h0001);
    check({15'h0, irq}, 16'h0000, "irq cleared");
    wr(OFS_CSR, 16'h0003);
    wr(OFS_CSR, 16'h0000);
    rd(OFS_IRQ_STAT, 16'h0006, "irq state change and exit");
    wr(OFS_IRQ_STAT, 16'h0006);
    // Status still pending from the earlier event, so enabling drives the line at once
    wr(OFS_CSR, 16'h0100);
    wake_pulse();
    check({15'h0, wake_line}, 16'h0000, "wake line pulled low");
    repeat (8) @(posedge mclk);
    rd(OFS_IRQ_STAT, 16'h0009, "irq wake and line fall");
    wr(OFS_CSR, 16'h8100);
    check({15'h0, wake_line}, 16'h0001, "wake line released");
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0000, "unmapped read");
    stop_test();
  end
endmodule
